// ===== hdl/port_io_crossbar_config.v
// port crossbar: priority pin assignment, pin drivers, pullups and register slave
`timescale 1ns/100ps
`include "port_xbar_consts.vh"

module port_io_crossbar_config
(
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // avalon-mm slave
  input  wire [9:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [3:0]  avs_byteenable,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // peripheral side
  input  wire [16:0] periph_out,
  input  wire [16:0] periph_drive,
  input  wire        serial_four_wire,
  output reg  [16:0] periph_in,
  // port pins, index 0..7 port 0, 8..15 port 1
  input  wire [15:0] pin_in,
  output reg  [15:0] pin_out,
  output reg  [15:0] pin_oe_n,
  output reg  [15:0] pin_pullup,
  output reg  [15:0] pin_rx_en
);

  // registers
  reg  [7:0]  crossbar_route_enables_a;
  reg  [7:0]  crossbar_route_enables_b;
  reg  [15:0] pin_input_mode_select;
  reg  [15:0] pin_output_drive_select;
  reg  [15:0] pin_crossbar_bypass;
  reg  [15:0] port_latch;

  // pin synchroniser
  reg  [15:0] pin_meta;
  reg  [15:0] pin_sync;

  // assignment results
  reg  [16:0] res_en;
  reg  [15:0] taken;
  reg  [15:0] owned;
  reg  [79:0] owner;
  reg  [67:0] res_pin;
  reg  [16:0] res_placed;
  reg         found;
  reg  [15:0] next_pin_out;
  reg  [15:0] next_pin_oe_n;
  reg  [15:0] next_pin_pullup;
  reg  [15:0] next_pin_rx_en;
  reg  [16:0] next_periph_in;
  reg  [31:0] next_readdata;
  reg  [15:0] pin_val;
  reg  [15:0] pin_want;
  reg  [15:0] pin_od;
  reg         drive;
  reg  [4:0]  own;
  // each combinational process keeps its own loop index
  integer     r;
  integer     p;
  integer     p2;
  integer     p3;
  integer     r2;

  wire [7:0]  reg_index;
  wire        reg_aligned;
  wire        bus_req;
  wire        wr_take;
  wire        wr_low;
  wire        crossbar_global_enable;
  wire        pullup_disable;
  wire [1:0]  pca_sel;

  assign reg_index   = avs_address[9:2];
  assign reg_aligned = (avs_address[1:0] == 2'h0);
  assign bus_req     = avs_read | avs_write;
  // write lands at the edge where waitrequest is seen low
  assign wr_take     = avs_write & ~avs_waitrequest & reg_aligned;
  // every register sits in byte lane 0
  assign wr_low      = wr_take & avs_byteenable[0];

  assign crossbar_global_enable = crossbar_route_enables_b[`RB_GLOBAL_ENABLE];
  assign pullup_disable         = crossbar_route_enables_b[`RB_PULLUP_DISABLE];
  assign pca_sel = crossbar_route_enables_b[`RB_PCA_HI:`RB_PCA_LO];

  // one wait state per access; idle waitrequest stays high
  // readdata loads on the edge that drops waitrequest, so it stands when sampled
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end
    else
    begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (avs_read & avs_waitrequest)
      begin
        avs_readdata <= next_readdata;
      end
    end
  end

  // read mux; unmapped or misaligned addresses read zero
  always @*
  begin
    next_readdata = 32'h0;
    if (reg_aligned)
    begin
      case (reg_index)
        `IDX_ROUTE_A:     next_readdata = {24'h0, crossbar_route_enables_a};
        `IDX_ROUTE_B:     next_readdata = {24'h0, crossbar_route_enables_b};
        `IDX_IN_MODE_0:   next_readdata = {24'h0, pin_input_mode_select[7:0]};
        `IDX_IN_MODE_1:   next_readdata = {24'h0, pin_input_mode_select[15:8]};
        `IDX_OUT_DRIVE_0: next_readdata = {24'h0, pin_output_drive_select[7:0]};
        `IDX_OUT_DRIVE_1: next_readdata = {24'h0, pin_output_drive_select[15:8]};
        `IDX_BYPASS_0:    next_readdata = {24'h0, pin_crossbar_bypass[7:0]};
        `IDX_BYPASS_1:    next_readdata = {24'h0, pin_crossbar_bypass[15:8]};
        `IDX_LATCH_0:     next_readdata = {24'h0, port_latch[7:0]};
        `IDX_LATCH_1:     next_readdata = {24'h0, port_latch[15:8]};
        // analog pins have no receiver and read as zero
        `IDX_LEVEL_0:     next_readdata = {24'h0, pin_sync[7:0] & pin_input_mode_select[7:0]};
        `IDX_LEVEL_1:     next_readdata = {24'h0, pin_sync[15:8] & pin_input_mode_select[15:8]};
        default:          next_readdata = 32'h0;
      endcase
    end
  end

  // route registers; masked bits are never stored and so read back zero
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      crossbar_route_enables_a <= `RST_ROUTE;
      crossbar_route_enables_b <= `RST_ROUTE;
    end
    else if (wr_low)
    begin
      case (reg_index)
        `IDX_ROUTE_A:
          crossbar_route_enables_a <= avs_writedata[7:0] & `ROUTE_A_WMASK;
        `IDX_ROUTE_B:
          crossbar_route_enables_b <= avs_writedata[7:0] & `ROUTE_B_WMASK;
        default:
          crossbar_route_enables_a <= crossbar_route_enables_a;
      endcase
    end
  end

  // pin configuration registers, low byte lane only
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_input_mode_select    <= {`RST_IN_MODE, `RST_IN_MODE};
      pin_output_drive_select  <= {`RST_OUT_DRIVE, `RST_OUT_DRIVE};
      pin_crossbar_bypass      <= {`RST_BYPASS, `RST_BYPASS};
      port_latch               <= {`RST_LATCH, `RST_LATCH};
    end
    else if (wr_low)
    begin
      case (reg_index)
        `IDX_IN_MODE_0:   pin_input_mode_select[7:0]    <= avs_writedata[7:0];
        `IDX_IN_MODE_1:   pin_input_mode_select[15:8]   <= avs_writedata[7:0];
        `IDX_OUT_DRIVE_0: pin_output_drive_select[7:0]  <= avs_writedata[7:0];
        `IDX_OUT_DRIVE_1: pin_output_drive_select[15:8] <= avs_writedata[7:0];
        `IDX_BYPASS_0:    pin_crossbar_bypass[7:0]      <= avs_writedata[7:0];
        `IDX_BYPASS_1:    pin_crossbar_bypass[15:8]     <= avs_writedata[7:0];
        `IDX_LATCH_0:     port_latch[7:0]               <= avs_writedata[7:0];
        `IDX_LATCH_1:     port_latch[15:8]              <= avs_writedata[7:0];
        default:          port_latch                    <= port_latch;
      endcase
    end
  end

  // two-stage synchroniser on the pin inputs
  // resets high so a pulled-up pin shows no false low right after reset
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta <= 16'hffff;
      pin_sync <= 16'hffff;
    end
    else
    begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // resource enables in priority order
  always @*
  begin
    res_en              = 17'h0;
    res_en[`RES_TX]     = crossbar_route_enables_a[`RA_ASYNC_SERIAL];
    res_en[`RES_RX]     = crossbar_route_enables_a[`RA_ASYNC_SERIAL];
    res_en[`RES_SCK]    = crossbar_route_enables_a[`RA_SERIAL_PERIPH];
    res_en[`RES_MISO]   = crossbar_route_enables_a[`RA_SERIAL_PERIPH];
    res_en[`RES_MOSI]   = crossbar_route_enables_a[`RA_SERIAL_PERIPH];
    res_en[`RES_NSS]    = crossbar_route_enables_a[`RA_SERIAL_PERIPH] & serial_four_wire;
    res_en[`RES_SDA]    = crossbar_route_enables_a[`RA_TWOWIRE];
    res_en[`RES_SCL]    = crossbar_route_enables_a[`RA_TWOWIRE];
    res_en[`RES_CP]     = crossbar_route_enables_a[`RA_COMP_OUT];
    res_en[`RES_CPA]    = crossbar_route_enables_a[`RA_COMP_ASYNC];
    res_en[`RES_SYSCLK] = crossbar_route_enables_a[`RA_CORE_CLOCK];
    res_en[`RES_PCA_CHANNEL_IO]   = (pca_sel != 2'h0);
    res_en[`RES_CEX1]   = pca_sel[1];
    res_en[`RES_CEX2]   = (pca_sel == 2'h3);
    res_en[`RES_ECI]    = crossbar_route_enables_b[`RB_ECI];
    res_en[`RES_T0]     = crossbar_route_enables_b[`RB_TIMER0];
    res_en[`RES_T1]     = crossbar_route_enables_b[`RB_TIMER1];
  end

  // priority decode: skipped pins start out as taken
  always @*
  begin
    taken      = pin_crossbar_bypass;
    owned      = 16'h0;
    owner      = 80'h0;
    res_pin    = 68'h0;
    res_placed = 17'h0;
    found      = 1'b0;
    // async serial keeps its fixed pins even if they are marked skipped
    if (res_en[`RES_TX])
    begin
      taken[`PIN_TX] = 1'b1;
      taken[`PIN_RX] = 1'b1;
      owned[`PIN_TX] = 1'b1;
      owned[`PIN_RX] = 1'b1;
      owner[`PIN_TX*5 +: 5] = 5'd`RES_TX;
      owner[`PIN_RX*5 +: 5] = 5'd`RES_RX;
      res_pin[`RES_TX*4 +: 4] = 4'd`PIN_TX;
      res_pin[`RES_RX*4 +: 4] = 4'd`PIN_RX;
      res_placed[`RES_TX] = 1'b1;
      res_placed[`RES_RX] = 1'b1;
    end
    for (r = `RES_SCK; r < `RES_COUNT; r = r + 1)
    begin
      found = 1'b0;
      for (p = 0; p < `NUM_PINS; p = p + 1)
      begin
        if (res_en[r] && !found && !taken[p])
        begin
          found         = 1'b1;
          taken[p]      = 1'b1;
          owned[p]      = 1'b1;
          owner[p*5 +: 5] = r[4:0];
          res_pin[r*4 +: 4] = p[3:0];
          res_placed[r] = 1'b1;
        end
      end
    end
  end

  // per-pin value, drive request and driver type
  always @*
  begin
    pin_val  = 16'h0;
    pin_want = 16'h0;
    pin_od   = 16'hffff;
    own      = 5'h0;
    for (p2 = 0; p2 < `NUM_PINS; p2 = p2 + 1)
    begin
      own = owner[p2*5 +: 5];
      if (owned[p2])
      begin
        pin_val[p2]  = periph_out[own];
        pin_want[p2] = periph_drive[own];
      end
      else
      begin
        // a gpio pin always asks to drive its latch; open-drain releases on 1
        pin_val[p2]  = port_latch[p2];
        pin_want[p2] = 1'b1;
      end
      // driver type from the mode bit alone, two-wire pins excepted
      pin_od[p2] = ~pin_output_drive_select[p2];
      if (owned[p2] && (own == `RES_SDA || own == `RES_SCL))
      begin
        pin_od[p2] = 1'b1;
      end
    end
  end

  // driver, pullup and receiver control from the decoded pin sources
  always @*
  begin
    next_pin_out    = 16'h0;
    next_pin_oe_n   = 16'hffff;
    next_pin_pullup = 16'h0;
    next_pin_rx_en  = 16'h0;
    drive           = 1'b0;
    for (p3 = 0; p3 < `NUM_PINS; p3 = p3 + 1)
    begin
      drive = crossbar_global_enable & pin_input_mode_select[p3] & pin_want[p3]
              & (~pin_od[p3] | ~pin_val[p3]);
      next_pin_out[p3]  = pin_val[p3] & ~pin_od[p3];
      next_pin_oe_n[p3] = ~drive;
      // pullup only on digital open-drain pins not pulling low
      next_pin_pullup[p3] = pin_input_mode_select[p3] & pin_od[p3]
                            & ~pullup_disable & ~(drive & ~pin_val[p3]);
      next_pin_rx_en[p3]  = pin_input_mode_select[p3];
    end
  end

  // pin levels back to the peripherals; idle high when not routed
  // a resource that found no free pin stays unplaced and also sees idle high
  always @*
  begin
    next_periph_in = 17'h1ffff;
    for (r2 = 0; r2 < `RES_COUNT; r2 = r2 + 1)
    begin
      if (crossbar_global_enable && res_placed[r2])
      begin
        next_periph_in[r2] = pin_sync[res_pin[r2*4 +: 4]]
                             | ~pin_input_mode_select[res_pin[r2*4 +: 4]];
      end
    end
  end

  // all pin controls take effect one cycle after the register change
  // registered so decode glitches never reach the pads
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_out    <= 16'h0;
      pin_oe_n   <= 16'hffff;
      pin_pullup <= 16'h0;
      pin_rx_en  <= 16'hffff;
      periph_in  <= 17'h1ffff;
    end
    else
    begin
      pin_out    <= next_pin_out;
      pin_oe_n   <= next_pin_oe_n;
      pin_pullup <= next_pin_pullup;
      pin_rx_en  <= next_pin_rx_en;
      periph_in  <= next_periph_in;
    end
  end

endmodule

// ===== hdl/port_xbar_consts.vh
// register map, field positions, reset values and resource slots of the port crossbar
`ifndef PORT_XBAR_CONSTS_VH
`define PORT_XBAR_CONSTS_VH

// register indices; byte address on the bus is four times the index
`define IDX_ROUTE_A        8'he1
`define IDX_ROUTE_B        8'he2
`define IDX_IN_MODE_0      8'h10
`define IDX_IN_MODE_1      8'h11
`define IDX_OUT_DRIVE_0    8'h12
`define IDX_OUT_DRIVE_1    8'h13
`define IDX_BYPASS_0       8'h14
`define IDX_BYPASS_1       8'h15
`define IDX_LATCH_0        8'h16
`define IDX_LATCH_1        8'h17
`define IDX_LEVEL_0        8'h18
`define IDX_LEVEL_1        8'h19

// writable masks: route_a bits 7:6 and route_b bit 2 read as zero
`define ROUTE_A_WMASK      8'h3f
`define ROUTE_B_WMASK      8'hfb

// field positions in route_a
`define RA_ASYNC_SERIAL    0
`define RA_SERIAL_PERIPH   1
`define RA_TWOWIRE         2
`define RA_CORE_CLOCK      3
`define RA_COMP_OUT        4
`define RA_COMP_ASYNC      5

// field positions in route_b
`define RB_PCA_LO          0
`define RB_PCA_HI          1
`define RB_ECI             3
`define RB_TIMER0          4
`define RB_TIMER1          5
`define RB_GLOBAL_ENABLE   6
`define RB_PULLUP_DISABLE  7

// reset values
`define RST_ROUTE          8'h00
`define RST_IN_MODE        8'hff
`define RST_OUT_DRIVE      8'h00
`define RST_BYPASS         8'h00
`define RST_LATCH          8'hff

// resource slots in priority order
`define RES_TX             0
`define RES_RX             1
`define RES_SCK            2
`define RES_MISO           3
`define RES_MOSI           4
`define RES_NSS            5
`define RES_SDA            6
`define RES_SCL            7
`define RES_CP             8
`define RES_CPA            9
`define RES_SYSCLK         10
`define RES_PCA_CHANNEL_IO           11
`define RES_CEX1           12
`define RES_CEX2           13
`define RES_ECI            14
`define RES_T0             15
`define RES_T1             16
`define RES_COUNT          17
`define NUM_PINS           16

// fixed pins of the async serial port
`define PIN_TX             4
`define PIN_RX             5

`endif

// ===== dv/xbar_monitor.sv
// concurrent checks of the port crossbar, bound to its top-level ports
`timescale 1ns/100ps
module xbar_monitor
(
  // clock, reset and register bus
  input wire        clk_sys,
  input wire        rst_n,
  input wire [9:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [3:0]  avs_byteenable,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  // peripheral and pin side
  input wire [16:0] periph_in,
  input wire [15:0] pin_out,
  input wire [15:0] pin_oe_n,
  input wire [15:0] pin_pullup,
  input wire [15:0] pin_rx_en
);
  reg  [7:0] shadow_b;
  wire       wr_done;
  wire       rd_done;
  assign wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign rd_done = avs_read && !avs_waitrequest;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // shadow of route_b: only global enable and pullup disable are used
  always @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      shadow_b <= 8'h00;
    else if (wr_done && avs_address == 10'h388)
      shadow_b <= avs_writedata[7:0];
  property p_wait_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("bus access not answered");
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_analog_off;
    (~pin_rx_en & (~pin_oe_n | pin_pullup)) == 16'h0000;
  endproperty
  a_analog_off: assert property (p_analog_off) else $error("analog pin active");
  property p_pullup_low;
    (~pin_oe_n & ~pin_out & pin_pullup) == 16'h0000;
  endproperty
  a_pullup_low: assert property (p_pullup_low) else $error("pullup on a low pin");
  property p_xbar_off;
    !shadow_b[6] |=> pin_oe_n == 16'hffff;
  endproperty
  a_xbar_off: assert property (p_xbar_off) else $error("driver on, crossbar off");
  property p_xbar_off_in;
    !shadow_b[6] [*4] |=> periph_in == 17'h1ffff;
  endproperty
  a_xbar_off_in: assert property (p_xbar_off_in) else $error("pin routed, xbar off");
  property p_reset_digital;
    $rose(rst_n) |-> pin_rx_en == 16'hffff;
  endproperty
  a_reset_digital: assert property (p_reset_digital) else $error("pin not digital");
  property p_route_a_top;
    rd_done && avs_address == 10'h384 |-> avs_readdata[31:6] == 26'h0;
  endproperty
  a_route_a_top: assert property (p_route_a_top) else $error("route_a top bits set");
  property p_mode_next;
    wr_done && avs_address == 10'h040 |-> ##2 pin_rx_en[7:0] == $past(avs_writedata[7:0], 2);
  endproperty
  a_mode_next: assert property (p_mode_next) else $error("input mode not applied");
  property p_pullup_disable;
    shadow_b[7] |=> pin_pullup == 16'h0000;
  endproperty
  a_pullup_disable: assert property (p_pullup_disable) else $error("pullup still on");
  cover property (wr_done && avs_address == 10'h388);
  cover property (rd_done && avs_address == 10'h384);
  cover property (shadow_b[6] && pin_oe_n != 16'hffff);
endmodule
bind port_io_crossbar_config xbar_monitor i_xbar_monitor (.clk_sys(clk_sys), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .periph_in(periph_in),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup), .pin_rx_en(pin_rx_en));

// ===== dv/pin_world.sv
// outside world of the port pins: resolves the level seen on each pin
`timescale 1ns/100ps
module pin_world
(
  // crossbar drivers
  input  wire        clk_sys,
  input  wire [15:0] pin_out,
  input  wire [15:0] pin_oe_n,
  input  wire [15:0] pin_pullup,
  // external drivers commanded by the bench
  input  wire [15:0] ext_en,
  input  wire [15:0] ext_val,
  // resolved levels
  output wire [15:0] pin_in
);
  reg [15:0] last = 16'h0000;
  // a floating, unpulled line flips every cycle so it never passes for a drive
  always @(posedge clk_sys)
    last <= pin_in;
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
                | (pin_oe_n & ~ext_en & (pin_pullup | ~last));
endmodule

// ===== dv/testbench.sv
// self-checking bench of the port crossbar: corner and random configurations
`timescale 1ns/100ps
module testbench;
  reg         clk_sys, rst_n, avs_read, avs_write, serial_four_wire;
  reg  [9:0]  avs_address;
  reg  [3:0]  avs_byteenable;
  reg  [31:0] avs_writedata;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest;
  reg  [16:0] periph_out, periph_drive;
  wire [16:0] periph_in;
  wire [15:0] pin_in, pin_out, pin_oe_n, pin_pullup, pin_rx_en;
  reg  [15:0] ext_en, ext_val, mdi, mdo, skp, lat, e_oe, e_out, e_pu, lm;
  reg  [16:0] e_pi, m_pi;
  reg  [7:0]  ra, rb, q;
  integer     num_errors, num_checks, i;
  port_io_crossbar_config i_port_io_crossbar_config (.clk_sys(clk_sys), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .periph_out(periph_out), .periph_drive(periph_drive),
    .serial_four_wire(serial_four_wire), .periph_in(periph_in), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup), .pin_rx_en(pin_rx_en));
  pin_world i_pin_world (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task finish_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk_reg(input [7:0] got, input [7:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("[FAIL] %0t register %h expected %h", $time, got, exp);
    end
  endtask
  task chk_pins(input [15:0] got, input [15:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("[FAIL] %0t pins %h expected %h", $time, got, exp);
    end
  endtask
  task chk_periph(input [16:0] got, input [16:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("[FAIL] %0t periph_in %h expected %h", $time, got, exp);
    end
  endtask
  // one register access; request held until waitrequest is sampled low
  task acc(input w, input [7:0] idx, input [7:0] d);
    @(posedge clk_sys);
    avs_address   <= {idx, 2'b00};
    avs_writedata <= {24'h000000, d};
    avs_write     <= w;
    avs_read      <= !w;
    // only the watchdog ends a wait that never gets an answer
    do
      @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  // expected pin drivers from the register image and peripheral requests
  function void model;
    integer    s, p;
    integer    own [16];
    reg [16:0] en;
    reg [15:0] tk;
    reg        od, w, v;
    en = {rb[5], rb[4], rb[3], rb[1:0] == 2'b11, rb[1], |rb[1:0], ra[3], ra[5], ra[4],
          {2{ra[2]}}, ra[1] & serial_four_wire, {3{ra[1]}}, {2{ra[0]}}};
    tk = skp | (ra[0] ? 16'h0030 : 16'h0000);
    e_pi = 17'h1ffff;
    m_pi = 17'h1ffff;
    for (p = 0; p < 16; p = p + 1)
      own[p] = (ra[0] && p == 4) ? 0 : (ra[0] && p == 5) ? 1 : -1;
    for (s = 2; s < 17; s = s + 1)
      for (p = 0; p < 16; p = p + 1)
        if (en[s] && !tk[p])
        begin
          own[p] = s;
          tk[p] = 1'b1;
          en[s] = 1'b0;
        end
    for (p = 0; p < 16; p = p + 1)
    begin
      od = !mdo[p] || own[p] == 6 || own[p] == 7;
      w = rb[6] && mdi[p] && (own[p] < 0 || periph_drive[own[p]]);
      v = own[p] < 0 ? lat[p] : periph_out[own[p]];
      e_oe[p] = !(w && (!od || !v));
      e_out[p] = !od && v;
      e_pu[p] = mdi[p] && od && !rb[7] && e_oe[p];
      // only analog pins and pins that are driven, pulled or held keep a level worth checking
      lm[p] = !mdi[p] || !e_oe[p] || ext_en[p] || e_pu[p];
      if (rb[6] && own[p] >= 0)
      begin
        e_pi[own[p]] = !mdi[p] || pin_in[p];
        m_pi[own[p]] = lm[p];
      end
    end
  endfunction
  // software order: modes, skips, latches, routes, then global enable
  task cfg;
    integer      k;
    reg   [63:0] wv;
    wv = {lat, skp, mdo, mdi};
    // crossbar off while the pins are reworked
    acc(1'b1, 8'he2, 8'h00);
    for (k = 0; k < 8; k = k + 1)
      acc(1'b1, 8'h10 + k[7:0], wv[8*k +: 8]);
    acc(1'b1, 8'he1, ra);
    acc(1'b1, 8'he2, rb);
    repeat (2) @(posedge clk_sys);
    model;
    chk_pins(pin_oe_n, e_oe);
    chk_pins(pin_out, e_out);
    chk_pins(pin_pullup, e_pu);
    chk_pins(pin_rx_en, mdi);
    acc(1'b0, 8'he1, 8'h00);
    chk_reg(q, ra & 8'h3f);
    acc(1'b0, 8'he2, 8'h00);
    chk_reg(q, rb & 8'hfb);
    acc(1'b0, 8'h18, 8'h00);
    chk_reg(q & lm[7:0], pin_in[7:0] & mdi[7:0] & lm[7:0]);
    acc(1'b0, 8'h19, 8'h00);
    chk_reg(q & lm[15:8], pin_in[15:8] & mdi[15:8] & lm[15:8]);
    chk_periph(periph_in & m_pi, e_pi & m_pi);
  endtask
  initial
  begin
    repeat (6000) @(posedge clk_sys);
    num_errors = num_errors + 1;
    finish_test;
  end
  initial
  begin
    {rst_n, avs_read, avs_write, avs_address, avs_writedata} = 0;
    {periph_out, periph_drive, serial_four_wire, ext_en, ext_val} = 0;
    avs_byteenable = 4'h1;
    num_errors = 0;
    num_checks = 0;
    void'($urandom(32'h0f01c133));
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (i = 0; i < 8; i = i + 1)
    begin
      acc(1'b0, 8'h10 + i[7:0], 8'h00);
      chk_reg(q, (i < 2 || i > 5) ? 8'hff : 8'h00);
    end
    acc(1'b0, 8'he2, 8'h00);
    chk_reg(q, 8'h00);
    chk_pins(pin_oe_n, 16'hffff);
    chk_pins(pin_pullup, 16'hffff);
    chk_pins(pin_rx_en, 16'hffff);
    acc(1'b1, 8'h30, 8'h5a);
    acc(1'b0, 8'h30, 8'h00);
    chk_reg(q, 8'h00);
    // three skipped pins push serial and pca resources onto later pins
    {mdi, mdo, skp, lat, ra, rb} = {16'hffff, 16'hffff, 16'h000d, 16'hffff, 8'h03, 8'h43};
    periph_drive <= 17'h1ffff;
    periph_out <= 17'h1dffb;
    serial_four_wire <= 1'b1;
    cfg;
    chk_pins(pin_out, 16'hf7fd);
    avs_byteenable <= 4'h0;
    acc(1'b1, 8'he1, 8'h00);
    avs_byteenable <= 4'h1;
    acc(1'b0, 8'he1, 8'h00);
    chk_reg(q, 8'h03);
    for (i = 0; i < 30; i = i + 1)
    begin
      {mdi, mdo, ra, rb} = {16'($urandom), 16'($urandom), 8'($urandom), 8'($urandom)};
      skp = 16'($urandom) | ~mdi;
      lat = 16'($urandom) | ~mdi;
      periph_out <= 17'($urandom);
      periph_drive <= 17'($urandom);
      serial_four_wire <= 1'($urandom);
      ext_en <= 16'($urandom);
      ext_val <= 16'($urandom);
      cfg;
    end
    finish_test;
  end
endmodule
